// [hw/i2cc_pkg.sv]
// constants, types and the rate table of the two-wire bus control block
// assumes an apb slave on one 200 mhz clock with open-drain scl/sda pads
package i2cc_pkg;
  localparam logic [7:0] I2CC_ADDR_FREQ  = 8'h00;
  localparam logic [7:0] I2CC_ADDR_CTRL  = 8'h04;
  localparam logic [7:0] I2CC_ADDR_DATA  = 8'h08;
  localparam logic [7:0] I2CC_ADDR_FLAGS = 8'h0c;
  localparam logic [7:0] I2CC_ADDR_MASK  = 8'h10;
  localparam int I2CC_CTL_EN   = 7;
  localparam int I2CC_CTL_IE   = 6;
  localparam int I2CC_CTL_MST  = 5;
  localparam int I2CC_CTL_TX   = 4;
  localparam int I2CC_CTL_ACK_DRIVE_VALUE = 3;
  localparam int I2CC_CTL_REPEATED_START_REQUEST = 2;
  localparam int I2CC_EV_DONE  = 0;
  localparam int I2CC_EV_ARB   = 1;
  localparam int I2CC_FL_BUSY  = 4;
  localparam int I2CC_FL_RXAK  = 5;
  localparam int I2CC_FL_MAST  = 6;
  localparam logic [3:0] I2CC_ACK_BIT = 4'h8;
  // every register, including the control fields, resets to zero
  localparam logic [7:0] I2CC_RST_VAL = 8'h00;

  typedef enum logic [3:0] {
    I2CC_IDLE, I2CC_START, I2CC_LOW, I2CC_HIGH, I2CC_WAIT,
    I2CC_RSLOW, I2CC_RSHIGH, I2CC_STOPLO, I2CC_STOPHI
  } i2cc_phase_t;

  typedef struct packed {
    logic [11:0] div;
    logic [9:0]  sda;
    logic [10:0] start;
    logic [10:0] stop;
  } i2cc_rate_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } i2cc_line_t;

  typedef struct packed {
    logic scl_o;
    logic scl_oe;
    logic sda_o;
    logic sda_oe;
  } i2cc_pins_t;

  function automatic logic [2:0] i2cc_mul(input logic [1:0] m);
    unique case (m)
      2'b00: return 3'h1;
      2'b01: return 3'h2;
      2'b10: return 3'h4;
      // reserved code: behaves as factor 1 rather than stopping the clock
      2'b11: return 3'h1;
    endcase
  endfunction

  function automatic logic [15:0] i2cc_scale(input logic [2:0] m,
                                             input logic [11:0] v);
    return 16'(m * v);
  endfunction

  function automatic i2cc_rate_t i2cc_rate(input logic [5:0] c);
    i2cc_rate_t r;
    r = '0;
    unique case (c)
      6'h00: r = '{12'd20, 10'd7, 11'd6, 11'd11};
      6'h01: r = '{12'd22, 10'd7, 11'd7, 11'd12};
      6'h02: r = '{12'd24, 10'd8, 11'd8, 11'd13};
      6'h03: r = '{12'd26, 10'd8, 11'd9, 11'd14};
      6'h04: r = '{12'd28, 10'd9, 11'd10, 11'd15};
      6'h05: r = '{12'd30, 10'd9, 11'd11, 11'd16};
      6'h06: r = '{12'd34, 10'd10, 11'd13, 11'd18};
      6'h07: r = '{12'd40, 10'd10, 11'd16, 11'd21};
      6'h08: r = '{12'd28, 10'd7, 11'd10, 11'd15};
      6'h09: r = '{12'd32, 10'd7, 11'd12, 11'd17};
      6'h0a: r = '{12'd36, 10'd9, 11'd14, 11'd19};
      6'h0b: r = '{12'd40, 10'd9, 11'd16, 11'd21};
      6'h0c: r = '{12'd44, 10'd11, 11'd18, 11'd23};
      6'h0d: r = '{12'd48, 10'd11, 11'd20, 11'd25};
      6'h0e: r = '{12'd56, 10'd13, 11'd24, 11'd29};
      6'h0f: r = '{12'd68, 10'd13, 11'd30, 11'd35};
      6'h10: r = '{12'd48, 10'd9, 11'd18, 11'd25};
      6'h11: r = '{12'd56, 10'd9, 11'd22, 11'd29};
      6'h12: r = '{12'd64, 10'd13, 11'd26, 11'd33};
      6'h13: r = '{12'd72, 10'd13, 11'd30, 11'd37};
      6'h14: r = '{12'd80, 10'd17, 11'd34, 11'd41};
      6'h15: r = '{12'd88, 10'd17, 11'd38, 11'd45};
      6'h16: r = '{12'd104, 10'd21, 11'd46, 11'd53};
      6'h17: r = '{12'd128, 10'd21, 11'd58, 11'd65};
      6'h18: r = '{12'd80, 10'd9, 11'd38, 11'd41};
      6'h19: r = '{12'd96, 10'd9, 11'd46, 11'd49};
      6'h1a: r = '{12'd112, 10'd17, 11'd54, 11'd57};
      6'h1b: r = '{12'd128, 10'd17, 11'd62, 11'd65};
      6'h1c: r = '{12'd144, 10'd25, 11'd70, 11'd73};
      6'h1d: r = '{12'd160, 10'd25, 11'd78, 11'd81};
      6'h1e: r = '{12'd192, 10'd33, 11'd94, 11'd97};
      6'h1f: r = '{12'd240, 10'd33, 11'd118, 11'd121};
      6'h20: r = '{12'd160, 10'd17, 11'd78, 11'd81};
      6'h21: r = '{12'd192, 10'd17, 11'd94, 11'd97};
      6'h22: r = '{12'd224, 10'd33, 11'd110, 11'd113};
      6'h23: r = '{12'd256, 10'd33, 11'd126, 11'd129};
      6'h24: r = '{12'd288, 10'd49, 11'd142, 11'd145};
      6'h25: r = '{12'd320, 10'd49, 11'd158, 11'd161};
      6'h26: r = '{12'd384, 10'd65, 11'd190, 11'd193};
      6'h27: r = '{12'd480, 10'd65, 11'd238, 11'd241};
      6'h28: r = '{12'd320, 10'd33, 11'd158, 11'd161};
      6'h29: r = '{12'd384, 10'd33, 11'd190, 11'd193};
      6'h2a: r = '{12'd448, 10'd65, 11'd222, 11'd225};
      6'h2b: r = '{12'd512, 10'd65, 11'd254, 11'd257};
      6'h2c: r = '{12'd576, 10'd97, 11'd286, 11'd289};
      6'h2d: r = '{12'd640, 10'd97, 11'd318, 11'd321};
      6'h2e: r = '{12'd768, 10'd129, 11'd382, 11'd385};
      6'h2f: r = '{12'd960, 10'd129, 11'd478, 11'd481};
      6'h30: r = '{12'd640, 10'd65, 11'd318, 11'd321};
      6'h31: r = '{12'd768, 10'd65, 11'd382, 11'd385};
      6'h32: r = '{12'd896, 10'd129, 11'd446, 11'd449};
      6'h33: r = '{12'd1024, 10'd129, 11'd510, 11'd513};
      6'h34: r = '{12'd1152, 10'd193, 11'd574, 11'd577};
      6'h35: r = '{12'd1280, 10'd193, 11'd638, 11'd641};
      6'h36: r = '{12'd1536, 10'd257, 11'd766, 11'd769};
      6'h37: r = '{12'd1920, 10'd257, 11'd958, 11'd961};
      6'h38: r = '{12'd1280, 10'd129, 11'd638, 11'd641};
      6'h39: r = '{12'd1536, 10'd129, 11'd766, 11'd769};
      6'h3a: r = '{12'd1792, 10'd257, 11'd894, 11'd897};
      6'h3b: r = '{12'd2048, 10'd257, 11'd1022, 11'd1025};
      6'h3c: r = '{12'd2304, 10'd385, 11'd1150, 11'd1153};
      6'h3d: r = '{12'd2560, 10'd385, 11'd1278, 11'd1281};
      6'h3e: r = '{12'd3072, 10'd513, 11'd1534, 11'd1537};
      6'h3f: r = '{12'd3840, 10'd513, 11'd1918, 11'd1921};
    endcase
    return r;
  endfunction
endpackage

// [hw/i2cc_top.sv]
// two-wire bus control, bit-rate generation and master byte engine
// assumes apb master on sys_clk; pads resolve scl/sda as wired-and
`timescale 1ns/1ps
`default_nettype none
module i2cc_top #(
  parameter int ADDR_W = 8
) (
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  input  wire i2cc_pkg::i2cc_line_t line_i,
  output i2cc_pkg::i2cc_pins_t   pins,
  output logic                   irq
);

  // every assertion below runs on sys_clk and sleeps through reset
  default clocking dflt_cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  typedef struct packed {
    logic                  pready;
    logic                  pslverr;
    logic [31:0]           prdata;
    logic [7:0]            freq;
    logic [7:0]            ctrl;
    logic [7:0]            data;
    logic [7:0]            shreg;
    logic [1:0]            flags;
    logic [1:0]            mask;
    logic                  irq;
    i2cc_pkg::i2cc_phase_t st;
    logic [15:0]           cnt;
    logic [3:0]            bitn;
    logic                  is_rx;
    logic                  rx_ack;
    logic                  master;
    logic                  busy;
    logic                  scl_s1;
    logic                  scl_s2;
    logic                  scl_d;
    logic                  sda_s1;
    logic                  sda_s2;
    logic                  sda_d;
    i2cc_pkg::i2cc_pins_t  pins;
  } i2cc_state_t;

  i2cc_state_t s;
  i2cc_state_t next_s;

  function automatic logic i2cc_hit(input logic [ADDR_W-1:0] a);
    logic [7:0] b;
    b = 8'(a);
    return (b == i2cc_pkg::I2CC_ADDR_FREQ) ||
           (b == i2cc_pkg::I2CC_ADDR_CTRL) ||
           (b == i2cc_pkg::I2CC_ADDR_DATA) ||
           (b == i2cc_pkg::I2CC_ADDR_FLAGS) ||
           (b == i2cc_pkg::I2CC_ADDR_MASK);
  endfunction

  // timing counts of the selected rate code, in sys_clk cycles
  i2cc_pkg::i2cc_rate_t rate;
  logic [2:0]           mul;
  logic [15:0]          half_c;
  logic [15:0]          hold_c;
  logic [15:0]          start_c;
  logic [15:0]          stop_c;
  assign rate = i2cc_pkg::i2cc_rate(s.freq[5:0]);
  assign mul = i2cc_pkg::i2cc_mul(s.freq[7:6]);
  assign half_c  = i2cc_pkg::i2cc_scale(mul, rate.div) >> 1;
  assign hold_c  = i2cc_pkg::i2cc_scale(mul, 12'(rate.sda));
  assign start_c = i2cc_pkg::i2cc_scale(mul, 12'(rate.start));
  assign stop_c  = i2cc_pkg::i2cc_scale(mul, 12'(rate.stop));

  logic       acc;
  logic       done;
  logic [7:0] a8;
  logic       wr_ctrl;
  logic       wr_data;
  logic       rd_data;
  logic       repeated_start_request_req;
  logic       ev_arb;
  logic       ev_done;
  logic       drive_bit;

  assign acc     = psel & penable;
  assign done    = acc & s.pready;
  assign a8      = 8'(paddr);
  assign wr_ctrl = done & pwrite & (a8 == i2cc_pkg::I2CC_ADDR_CTRL);
  assign wr_data = done & pwrite & (a8 == i2cc_pkg::I2CC_ADDR_DATA);
  assign rd_data = done & ~pwrite & (a8 == i2cc_pkg::I2CC_ADDR_DATA);
  assign repeated_start_request_req = wr_ctrl & pwdata[i2cc_pkg::I2CC_CTL_REPEATED_START_REQUEST]
                    & s.ctrl[i2cc_pkg::I2CC_CTL_EN];
  // released (1) unless a transmitted zero or a receive acknowledge
  assign drive_bit = (s.bitn == i2cc_pkg::I2CC_ACK_BIT)
                   ? (~s.is_rx | s.ctrl[i2cc_pkg::I2CC_CTL_ACK_DRIVE_VALUE])
                   : (s.is_rx | s.shreg[7]);

  always_comb
  begin
    next_s = s;
    ev_arb = 1'b0;
    ev_done = 1'b0;
    next_s.scl_s1 = line_i.scl;
    next_s.scl_s2 = s.scl_s1;
    next_s.scl_d  = s.scl_s2;
    next_s.sda_s1 = line_i.sda;
    next_s.sda_s2 = s.sda_s1;
    next_s.sda_d  = s.sda_s2;
    if (s.scl_s2 & s.scl_d & s.sda_d & ~s.sda_s2)
      next_s.busy = 1'b1;
    if (s.scl_s2 & s.scl_d & ~s.sda_d & s.sda_s2)
      next_s.busy = 1'b0;

    // apb: one wait state, answer registered
    next_s.pready  = acc & ~s.pready;
    next_s.pslverr = acc & ~s.pready & ~i2cc_hit(paddr);
    if (acc & ~s.pready)
    begin
      next_s.prdata = '0;
      unique case (a8)
        i2cc_pkg::I2CC_ADDR_FREQ:
          next_s.prdata[7:0] = s.freq;
        i2cc_pkg::I2CC_ADDR_CTRL:
          next_s.prdata[7:0] = s.ctrl;
        i2cc_pkg::I2CC_ADDR_DATA:
          next_s.prdata[7:0] = s.data;
        i2cc_pkg::I2CC_ADDR_FLAGS:
        begin
          next_s.prdata[1:0] = s.flags;
          next_s.prdata[i2cc_pkg::I2CC_FL_BUSY] = s.busy;
          next_s.prdata[i2cc_pkg::I2CC_FL_RXAK] = s.rx_ack;
          next_s.prdata[i2cc_pkg::I2CC_FL_MAST] = s.master;
        end
        i2cc_pkg::I2CC_ADDR_MASK:
          next_s.prdata[1:0] = s.mask;
        default:
          next_s.prdata = '0;
      endcase
    end
    if (done & pwrite)
    begin
      unique case (a8)
        i2cc_pkg::I2CC_ADDR_FREQ: next_s.freq = pwdata[7:0];
        i2cc_pkg::I2CC_ADDR_CTRL:
          next_s.ctrl = {pwdata[7:3], 3'h0};
        i2cc_pkg::I2CC_ADDR_MASK: next_s.mask = pwdata[1:0];
        default: next_s.freq = s.freq;
      endcase
    end

    unique case (s.st)
      i2cc_pkg::I2CC_IDLE:
      begin
        next_s.pins.scl_oe = 1'b0;
        next_s.pins.sda_oe = 1'b0;
        // rising select: pull sda low while scl high
        if (wr_ctrl & pwdata[i2cc_pkg::I2CC_CTL_MST]
            & ~s.ctrl[i2cc_pkg::I2CC_CTL_MST]
            & pwdata[i2cc_pkg::I2CC_CTL_EN])
        begin
          if (s.busy)
          begin
            ev_arb = 1'b1;
            next_s.ctrl[i2cc_pkg::I2CC_CTL_MST] = 1'b0;
          end
          else
          begin
            next_s.master = 1'b1;
            next_s.pins.sda_oe = 1'b1;
            next_s.cnt = '0;
            next_s.st = i2cc_pkg::I2CC_START;
          end
        end
      end
      i2cc_pkg::I2CC_START:
      begin
        next_s.cnt = s.cnt + 16'h0001;
        if (s.cnt >= start_c)
        begin
          next_s.pins.scl_oe = 1'b1;
          next_s.st = i2cc_pkg::I2CC_WAIT;
        end
      end
      i2cc_pkg::I2CC_WAIT:
      begin
        next_s.cnt = '0;
        next_s.bitn = '0;
        // falling select ends with a stop
        if (~s.ctrl[i2cc_pkg::I2CC_CTL_MST])
          next_s.st = i2cc_pkg::I2CC_STOPLO;
        // direction picks which access starts a byte
        else if (wr_data & s.ctrl[i2cc_pkg::I2CC_CTL_TX])
        begin
          next_s.shreg = pwdata[7:0];
          next_s.is_rx = 1'b0;
          next_s.st = i2cc_pkg::I2CC_LOW;
        end
        else if (rd_data & ~s.ctrl[i2cc_pkg::I2CC_CTL_TX])
        begin
          next_s.shreg = 8'hff;
          next_s.is_rx = 1'b1;
          next_s.st = i2cc_pkg::I2CC_LOW;
        end
      end
      i2cc_pkg::I2CC_LOW:
      begin
        next_s.cnt = s.cnt + 16'h0001;
        // data changes one hold time after scl fell
        if (s.cnt == hold_c)
          next_s.pins.sda_oe = ~drive_bit;
        if (s.cnt >= half_c)
        begin
          next_s.pins.scl_oe = 1'b0;
          next_s.cnt = '0;
          next_s.st = i2cc_pkg::I2CC_HIGH;
        end
      end
      i2cc_pkg::I2CC_HIGH:
      begin
        // count only while scl is seen high, so a stretching slave waits
        if (s.scl_s2)
          next_s.cnt = s.cnt + 16'h0001;
        if (s.scl_s2 & (s.cnt == '0))
        begin
          if (s.bitn == i2cc_pkg::I2CC_ACK_BIT)
            next_s.rx_ack = s.sda_s2;
          else
            next_s.shreg = {s.shreg[6:0], s.sda_s2};
          if (~s.is_rx & ~s.pins.sda_oe & ~s.sda_s2
              & (s.bitn != i2cc_pkg::I2CC_ACK_BIT))
          begin
            ev_arb = 1'b1;
            next_s.master = 1'b0;
            next_s.ctrl[i2cc_pkg::I2CC_CTL_MST] = 1'b0;
            next_s.st = i2cc_pkg::I2CC_IDLE;
          end
        end
        if (s.scl_s2 & (s.cnt >= half_c))
        begin
          next_s.pins.scl_oe = 1'b1;
          next_s.cnt = '0;
          next_s.bitn = s.bitn + 4'h1;
          next_s.st = i2cc_pkg::I2CC_LOW;
          if (s.bitn == i2cc_pkg::I2CC_ACK_BIT)
          begin
            ev_done = 1'b1;
            if (s.is_rx)
              next_s.data = s.shreg;
            next_s.st = i2cc_pkg::I2CC_WAIT;
          end
        end
      end
      i2cc_pkg::I2CC_RSLOW:
      begin
        next_s.cnt = s.cnt + 16'h0001;
        if (s.cnt == hold_c)
          next_s.pins.sda_oe = 1'b0;
        if (s.cnt >= half_c)
        begin
          next_s.pins.scl_oe = 1'b0;
          next_s.cnt = '0;
          next_s.st = i2cc_pkg::I2CC_RSHIGH;
        end
      end
      i2cc_pkg::I2CC_RSHIGH:
      begin
        if (s.scl_s2)
          next_s.cnt = s.cnt + 16'h0001;
        if (s.scl_s2 & (s.cnt >= half_c))
        begin
          next_s.pins.sda_oe = 1'b1;
          next_s.cnt = '0;
          next_s.st = i2cc_pkg::I2CC_START;
        end
      end
      i2cc_pkg::I2CC_STOPLO:
      begin
        next_s.cnt = s.cnt + 16'h0001;
        if (s.cnt == hold_c)
          next_s.pins.sda_oe = 1'b1;
        if (s.cnt >= half_c)
        begin
          next_s.pins.scl_oe = 1'b0;
          next_s.cnt = '0;
          next_s.st = i2cc_pkg::I2CC_STOPHI;
        end
      end
      i2cc_pkg::I2CC_STOPHI:
      begin
        if (s.scl_s2)
          next_s.cnt = s.cnt + 16'h0001;
        if (s.scl_s2 & (s.cnt >= stop_c))
        begin
          next_s.pins.sda_oe = 1'b0;
          next_s.master = 1'b0;
          next_s.st = i2cc_pkg::I2CC_IDLE;
        end
      end
    endcase

    if (repeated_start_request_req)
    begin
      // repeated start only from a byte boundary as master
      if (s.master & (s.st == i2cc_pkg::I2CC_WAIT))
      begin
        next_s.cnt = '0;
        next_s.st = i2cc_pkg::I2CC_RSLOW;
      end
      // wrong moment is reported as arbitration lost
      else
      begin
        ev_arb = 1'b1;
      end
    end

    // enable bit gates every link action
    if (~s.ctrl[i2cc_pkg::I2CC_CTL_EN])
    begin
      next_s.pins.scl_oe = 1'b0;
      next_s.pins.sda_oe = 1'b0;
      next_s.master = 1'b0;
      next_s.st = i2cc_pkg::I2CC_IDLE;
    end

    // set wins over a write-one clear in the same cycle
    next_s.flags = s.flags & ~((done & pwrite
                   & (a8 == i2cc_pkg::I2CC_ADDR_FLAGS))
                   ? pwdata[1:0] : 2'h0);
    next_s.flags[i2cc_pkg::I2CC_EV_DONE] =
      next_s.flags[i2cc_pkg::I2CC_EV_DONE] | ev_done;
    next_s.flags[i2cc_pkg::I2CC_EV_ARB] =
      next_s.flags[i2cc_pkg::I2CC_EV_ARB] | ev_arb;
    // request gated by the interrupt enable bit
    next_s.irq = s.ctrl[i2cc_pkg::I2CC_CTL_IE] & |(s.flags & s.mask);
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= next_s;
  end

  assign pready  = s.pready;
  assign prdata  = s.prdata;
  assign pslverr = s.pslverr;
  assign pins    = s.pins;
  assign irq     = s.irq;

  sequence stop_end_s;
    !s.pins.sda_oe && !s.master;
  endsequence

  a_repeated_start_request_reads_zero: assert property (
    done && !pwrite && a8 == i2cc_pkg::I2CC_ADDR_CTRL
    |-> !prdata[i2cc_pkg::I2CC_CTL_REPEATED_START_REQUEST])
    else $error("repeated start bit read back as one");
  a_irq_gated: assert property (
    !s.ctrl[i2cc_pkg::I2CC_CTL_IE] |=> !irq)
    else $error("interrupt raised while disabled");
  a_off_released: assert property (
    !s.ctrl[i2cc_pkg::I2CC_CTL_EN] |=> !pins.scl_oe && !pins.sda_oe)
    else $error("line driven while module disabled");
  a_enable_store: assert property (
    wr_ctrl |=> s.ctrl[i2cc_pkg::I2CC_CTL_EN]
                == $past(pwdata[i2cc_pkg::I2CC_CTL_EN]))
    else $error("enable bit not taken");
  a_start_cond: assert property (
    $rose(s.master) |-> pins.sda_oe && !pins.scl_oe)
    else $error("start not sda low with scl high");
  a_stop_cond: assert property (
    (s.st == i2cc_pkg::I2CC_STOPHI && s.scl_s2 && s.cnt >= stop_c
     && s.ctrl[i2cc_pkg::I2CC_CTL_EN]) |=> stop_end_s)
    else $error("stop did not release sda");
  a_sda_hold: assert property (
    (s.st == i2cc_pkg::I2CC_LOW && s.cnt != hold_c
     && s.ctrl[i2cc_pkg::I2CC_CTL_EN]) |=> $stable(pins.sda_oe))
    else $error("sda moved outside its hold point");
  a_scl_half: assert property (
    (s.st == i2cc_pkg::I2CC_LOW && s.cnt >= half_c
     && s.ctrl[i2cc_pkg::I2CC_CTL_EN]) |=> !pins.scl_oe)
    else $error("scl low phase not ended at half period");
  a_rate_multiplier_two: assert property (
    s.freq[7:6] == 2'b01 |-> half_c == 16'(rate.div))
    else $error("multiplier two not applied");
  a_rate_first: assert property (
    s.freq == 8'h00 |-> half_c == 16'h000a && hold_c == 16'h0007)
    else $error("code zero counts wrong");
  a_ack_level: assert property (
    (s.st == i2cc_pkg::I2CC_LOW && s.is_rx && s.cnt == hold_c
     && s.bitn == i2cc_pkg::I2CC_ACK_BIT && s.ctrl[i2cc_pkg::I2CC_CTL_EN])
    |=> pins.sda_oe == !$past(s.ctrl[i2cc_pkg::I2CC_CTL_ACK_DRIVE_VALUE]))
    else $error("acknowledge level wrong");
  a_repeated_start_request_bad: assert property (
    (repeated_start_request_req && !(s.master && s.st == i2cc_pkg::I2CC_WAIT))
    |=> s.flags[i2cc_pkg::I2CC_EV_ARB])
    else $error("bad repeated start not flagged");
  a_repeated_start_request_go: assert property (
    (repeated_start_request_req && s.master && s.st == i2cc_pkg::I2CC_WAIT)
    |=> s.st == i2cc_pkg::I2CC_RSLOW)
    else $error("repeated start not begun");
  a_dir_receive: assert property (
    (s.st == i2cc_pkg::I2CC_WAIT && wr_data && !s.ctrl[i2cc_pkg::I2CC_CTL_TX]
     && s.ctrl[i2cc_pkg::I2CC_CTL_MST] && !repeated_start_request_req)
    |=> s.st == i2cc_pkg::I2CC_WAIT)
    else $error("data write started a byte in receive");

endmodule
`default_nettype wire

// [sim/i2cc_slave_model.sv]
// far-side slave on the two-wire bus: acks on request, records bits seen
// assumes scl and sda are the resolved wired-and levels
`timescale 1ns/1ps
`default_nettype none
module i2cc_slave_model (
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic ack_en,
  output logic      sda_oe,
  output logic [8:0] bits,
  output logic [7:0] starts
);
  int n = 0;
  initial sda_oe = 0;
  initial bits = 0;
  initial starts = 0;
  always @(negedge sda)
    if (scl === 1'b1)
    begin
      n = 0;
      starts++;
    end
  always @(posedge scl) bits <= {bits[7:0], sda};
  // ack slot timing
  // falls: start, then eight data bits; the ninth low phase is the ack
  always @(negedge scl)
  begin
    n++;
    sda_oe <= ack_en && n % 9 == 0;
  end
endmodule
`default_nettype wire

// [sim/tb.sv]
// bench for the two-wire control block: apb master plus one slave model
// assumes pull-ups on both lines and one 200 mhz clock
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0, starts;
  logic [31:0] pwdata = 0, prdata, r;
  logic pready, pslverr, irq, s_oe, ack_en = 1;
  logic [8:0] bits;
  i2cc_pkg::i2cc_line_t line;
  i2cc_pkg::i2cc_pins_t pins;
  int fail_count = 0, n_compared = 0, seed = 32'h26a8b653;
  logic [32:0] eq[$];
  logic [31:0] mq[$];
  always #2.5 sys_clk = ~sys_clk;
  assign line = {!pins.scl_oe, !(pins.sda_oe | s_oe)};
  i2cc_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .line_i(line),
    .pins(pins), .irq(irq));
  i2cc_slave_model slv (.scl(line.scl), .sda(line.sda), .ack_en(ack_en),
    .sda_oe(s_oe), .bits(bits), .starts(starts));
  task automatic chk(string nm, logic [32:0] s, logic [32:0] e);
    n_compared++;
    if (s !== e)
    begin
      fail_count++;
      $display("[FAIL] %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge sys_clk);
    penable <= 1;
    // only the watchdog ends a wait for the answer
    do @(posedge sys_clk); while (pready !== 1'b1);
    {psel, penable} <= 2'b00;
    @(posedge sys_clk);
  endtask
  task automatic rd(logic [7:0] a, logic [32:0] e, logic [31:0] m);
    eq.push_back(e);
    mq.push_back(m);
    apb(0, a, 0);
  endtask
  // read results are matched to the oldest note in the queue
  always @(posedge sys_clk)
    if (psel && penable && pready === 1'b1 && !pwrite && eq.size() > 0)
      chk("read", {pslverr, prdata & mq.pop_front()},
          eq.pop_front());
  task automatic wirq();
    int k;
    k = 0;
    while (irq !== 1'b1 && k++ < 4000) @(posedge sys_clk);
    chk("irq", irq, 1);
    apb(1, 8'h0c, 3);
  endtask
  task automatic wrap_up();
    $display("compared %0d failed %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    #200us;
    fail_count++;
    wrap_up();
  end
  initial
  begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1;
    @(posedge sys_clk);
    rd(8'h04, 0, 8'hff);
    rd(8'h14, 33'h100000000, 8'hff);
    for (int i = 0; i < 3; i++)
    begin
      // every legal multiplier once, random rate code
      r = ($random(seed) & 32'h3f) | (i << 6);
      apb(1, 8'h00, r);
      rd(8'h00, r, 8'hff);
    end
    apb(1, 8'h00, 0);
    apb(1, 8'h04, 8'hc0);
    // enabled first, so the bad repeated start is not ignored
    apb(1, 8'h04, 8'hc4);
    rd(8'h04, 8'hc0, 8'hff);
    rd(8'h0c, 2, 8'h43);
    chk("irq", irq, 0);
    apb(1, 8'h10, 3);
    // irq lags the flags by one cycle
    @(posedge sys_clk);
    chk("irq", irq, 1);
    apb(1, 8'h04, 8'h80);
    repeat (2) @(posedge sys_clk);
    chk("irq", irq, 0);
    apb(1, 8'h0c, 3);
    // transmit kept set for the address byte, as software must
    apb(1, 8'h04, 8'hf0);
    @(posedge sys_clk);
    chk("sda_oe", pins.sda_oe, 1);
    chk("scl_oe", pins.scl_oe, 0);
    repeat (10) @(posedge sys_clk);
    rd(8'h0c, 8'h50, 8'h50);
    r = $random(seed) & 32'hff;
    apb(1, 8'h08, r);
    wirq();
    chk("byte", bits[8:1], r);
    rd(8'h0c, 0, 8'h20);
    ack_en <= 0;
    // software sets direction itself before every transfer
    for (int t = 0; t < 2; t++)
    begin
      apb(1, 8'h04, 8'he0 | t << 3);
      // a data write in receive must not start a byte
      apb(1, 8'h08, 0);
      apb(0, 8'h08, 0);
      wirq();
      chk("ack", bits[0], t);
    end
    apb(1, 8'h04, 8'hf0);
    rd(8'h08, 8'hff, 8'hff);
    r = starts;
    apb(1, 8'h04, 8'hf4);
    repeat (60) @(posedge sys_clk);
    chk("starts", starts, r + 1);
    rd(8'h0c, 0, 8'h02);
    apb(1, 8'h04, 8'hc0);
    repeat (60) @(posedge sys_clk);
    rd(8'h0c, 0, 8'h50);
    chk("lines", {pins.scl_oe, pins.sda_oe}, 0);
    apb(1, 8'h04, 8'h20);
    repeat (20) @(posedge sys_clk);
    chk("lines", {pins.scl_oe, pins.sda_oe}, 0);
    rd(8'h0c, 0, 8'h50);
    wrap_up();
  end
endmodule
`default_nettype wire
